/* tile_debug_status_regs.vh */
// Operation
// R1 - four 16-bit oscillator counts at 0x07..0x0a: tile cell, tile wire, periph cell, wire
// R2 - oscillator counts are not cleared by system reset
// R3 - read-only RAM size in bytes in bits 31:2, bits 1:0 reserved
// R4 - debugger entry captures the interrupted thread's saved status word
// R5 - status bits 0..4: events, interrupts, event sequence, handler, kernel mode
// R6 - status bit 6 paused waiting, bit 7 fast continual issue
// R7 - status bit 8 issue mode read-only, bit 9 kernel-entry issue mode, bit 10 space id
// R8 - debugger entry captures full 32-bit saved program counter
// R9 - debugger entry captures full 32-bit saved stack pointer
// R10 - fetch thread operand is 8 bits in bits 7:0
// R11 - fetch register operand is 5 bits in bits 4:0
// R12 - cause in bits 2:0, reset 0; codes 1 host to 5 resource watch
// R13 - raising thread number in bits 15:8, zero for host requests
// R14 - trigger number in bits 17:16, zero for host or call, lowest wins
// R15 - data watch loads effective address, resource watch loads resource id
// R16 - stop mask bits 7:0 hold threads stopped while outside debug mode
// R17 - on debug return, masked threads stay stopped for single stepping
// R18 - eight 32-bit scratch words at 0x20..0x27 shared with tile config
// R19 - debug-writable fields accept writes only in debug mode
// R20 - reserved bits read zero and ignore writes
`ifndef TILE_DEBUG_STATUS_REGS_VH
`define TILE_DEBUG_STATUS_REGS_VH

// register indices; byte address is index times four
`define IDX_TILE_CELL_OSC   8'h07
`define IDX_TILE_WIRE_OSC   8'h08
`define IDX_PERIPH_CELL_OSC 8'h09
`define IDX_PERIPH_WIRE_OSC 8'h0a
`define IDX_MEMORY_SIZE     8'h0c
`define IDX_SAVED_STATUS    8'h10
`define IDX_SAVED_PC        8'h11
`define IDX_SAVED_STACK     8'h12
`define IDX_FETCH_THREAD    8'h13
`define IDX_FETCH_REGISTER  8'h14
`define IDX_DEBUG_CAUSE     8'h15
`define IDX_CAUSE_DATA      8'h16
`define IDX_STOP_MASK       8'h18
`define IDX_SCRATCH_BASE    8'h20
`define IDX_SCRATCH_LAST    8'h27

// field masks of writable bits and field bit positions
`define STATUS_WR_MASK      32'h0000_06df
`define STATUS_ISSUE_BIT    8
`define CAUSE_WR_MASK       32'h0003_ff07
`define CAUSE_THREAD_LSB    8
`define CAUSE_NUM_LSB       16

// cause codes
`define CAUSE_NONE          3'h0
`define CAUSE_HOST          3'h1
`define CAUSE_CALL          3'h2
`define CAUSE_IBREAK        3'h3
`define CAUSE_DWATCH        3'h4
`define CAUSE_RWATCH        3'h5

// reset values
`define CAUSE_RESET         3'h0
`define STOP_MASK_RESET     8'h00

`endif

/* scratch_memory.v */
module scratch_memory
#(
  parameter DEPTH_LOG2 = 3,
  parameter WIDTH      = 32
)
(
  // clock
  input  wire                  clock,
  // port a
  input  wire                  a_we,
  input  wire [DEPTH_LOG2-1:0] a_addr,
  input  wire [WIDTH-1:0]      a_wdata,
  output reg  [WIDTH-1:0]      a_rdata,
  // port b
  input  wire                  b_we,
  input  wire [DEPTH_LOG2-1:0] b_addr,
  input  wire [WIDTH-1:0]      b_wdata,
  output reg  [WIDTH-1:0]      b_rdata
);

  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

  // one shared store, port a wins a same-word write
  always @(posedge clock)
  begin
    if (b_we && !(a_we && a_addr == b_addr))
      mem[b_addr] <= b_wdata;
    if (a_we)
      mem[a_addr] <= a_wdata; // R18
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule // scratch_memory

/* tile_debug_status_registers.v */
`include "tile_debug_status_regs.vh"

module tile_debug_status_registers
#(
  parameter [31:0] RAM_SIZE_BYTES = 32'h0008_0000,
  parameter        THREADS        = 8
)
(
  // clock and reset
  input  wire               clock,
  input  wire               rst,
  // ahb-lite slave
  input  wire               hsel,
  input  wire [31:0]        haddr,
  input  wire [1:0]         htrans,
  input  wire               hwrite,
  input  wire [2:0]         hsize,
  input  wire [31:0]        hwdata,
  input  wire               hready,
  output wire               hreadyout,
  output wire               hresp,
  output reg  [31:0]        hrdata,
  // ring oscillator counters, asynchronous
  input  wire [15:0]        tile_cell_osc,
  input  wire [15:0]        tile_wire_osc,
  input  wire [15:0]        periph_cell_osc,
  input  wire [15:0]        periph_wire_osc,
  // core debug state
  input  wire               debug_mode,
  input  wire               debug_entry,
  input  wire               debug_return,
  input  wire [31:0]        entry_saved_status_word,
  input  wire [31:0]        entry_saved_program_counter,
  input  wire [31:0]        entry_saved_stack_pointer,
  input  wire [2:0]         entry_cause,
  input  wire [7:0]         entry_thread,
  input  wire [3:0]         entry_trigger_hits,
  input  wire [31:0]        entry_effective_address,
  input  wire [31:0]        entry_resource_id,
  input  wire               current_issue_mode,
  // debug register fetch operands
  output wire [7:0]         fetch_thread,
  output wire [4:0]         fetch_register,
  // thread run control
  output wire [THREADS-1:0] thread_stop,
  // tile configuration scratch port
  input  wire               cfg_scratch_we,
  input  wire [2:0]         cfg_scratch_addr,
  input  wire [31:0]        cfg_scratch_wdata,
  output wire [31:0]        cfg_scratch_rdata
);

  //////////////////////////////////////////////////////////////////////////////
  // oscillator count synchronisers, no reset on purpose

  reg [63:0] osc_meta_q;
  reg [63:0] osc_sync_q;

  always @(posedge clock)
  begin
    osc_meta_q <= {periph_wire_osc, periph_cell_osc,
                   tile_wire_osc, tile_cell_osc};
    osc_sync_q <= osc_meta_q; // R2
  end

  //////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase capture

  reg        dph_valid_q;
  reg        dph_write_q;
  reg [7:0]  dph_index_q;
  reg        rd_pend_q;

  wire       take = hsel && hready && htrans[1];

  always @(posedge clock)
  begin
    if (rst)
    begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_index_q <= 8'h00;
    end
    else if (hready)
    begin
      dph_valid_q <= take;
      dph_write_q <= hwrite;
      dph_index_q <= haddr[9:2];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire wr_en = dph_valid_q && dph_write_q;
  wire dbg_wr = wr_en && debug_mode; // R19

  //////////////////////////////////////////////////////////////////////////////
  // debug state registers

  reg [31:0]        status_q;
  reg [31:0]        pc_q;
  reg [31:0]        stack_q;
  reg [7:0]         fthread_q;
  reg [4:0]         freg_q;
  reg [31:0]        cause_q;
  reg [31:0]        cdata_q;
  reg [THREADS-1:0] stop_q;
  reg               issue_q;

  reg [1:0] trig_num;
  integer   i;

  // lowest triggering comparator number
  always @*
  begin
    trig_num = 2'd0;
    for (i = 3; i >= 0; i = i - 1)
      if (entry_trigger_hits[i])
        trig_num = i[1:0]; // R14
  end

  wire cause_has_num = (entry_cause == `CAUSE_IBREAK) ||
                       (entry_cause == `CAUSE_DWATCH) ||
                       (entry_cause == `CAUSE_RWATCH);

  always @(posedge clock)
  begin
    if (rst)
    begin
      status_q  <= 32'h0000_0000;
      pc_q      <= 32'h0000_0000;
      stack_q   <= 32'h0000_0000;
      fthread_q <= 8'h00;
      freg_q    <= 5'h00;
      cause_q   <= 32'h0000_0000; // R12
      cdata_q   <= 32'h0000_0000;
      stop_q    <= {THREADS{1'b0}};
      issue_q   <= 1'b0;
    end
    else
    begin
      issue_q <= current_issue_mode; // R7
      if (debug_entry)
      begin
        status_q <= entry_saved_status_word & `STATUS_WR_MASK; // R4 R5 R6 R7
        pc_q     <= entry_saved_program_counter; // R8
        stack_q  <= entry_saved_stack_pointer; // R9
        cause_q  <= {14'h0000,
                     (cause_has_num ? trig_num : 2'd0),
                     ((entry_cause == `CAUSE_HOST) ? 8'h00 : entry_thread),
                     5'h00, entry_cause}; // R12 R13 R14
        if (entry_cause == `CAUSE_DWATCH)
          cdata_q <= entry_effective_address; // R15
        else if (entry_cause == `CAUSE_RWATCH)
          cdata_q <= entry_resource_id; // R15
      end
      else if (dbg_wr)
      begin
        case (dph_index_q)
          `IDX_SAVED_STATUS:
            status_q <= hwdata & `STATUS_WR_MASK; // R20
          `IDX_SAVED_PC:
            pc_q <= hwdata;
          `IDX_SAVED_STACK:
            stack_q <= hwdata;
          `IDX_FETCH_THREAD:
            fthread_q <= hwdata[7:0]; // R10
          `IDX_FETCH_REGISTER:
            freg_q <= hwdata[4:0]; // R11
          `IDX_DEBUG_CAUSE:
            cause_q <= hwdata & `CAUSE_WR_MASK; // R20
          `IDX_CAUSE_DATA:
            cdata_q <= hwdata;
          `IDX_STOP_MASK:
            stop_q <= hwdata[THREADS-1:0]; // R16
          default:
            cdata_q <= cdata_q;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // thread stop: masked threads held while outside debug mode

  assign thread_stop = debug_mode ? {THREADS{1'b0}} : stop_q; // R16 R17
  assign fetch_thread   = fthread_q;
  assign fetch_register = freg_q;

  //////////////////////////////////////////////////////////////////////////////
  // scratch words shared with the tile configuration port

  wire        scr_hit = (dph_index_q >= `IDX_SCRATCH_BASE) &&
                        (dph_index_q <= `IDX_SCRATCH_LAST);
  wire [31:0] scr_rdata;

  scratch_memory #(
    .DEPTH_LOG2 (3),
    .WIDTH      (32)
  ) u_scratch (
    .clock   (clock),
    .a_we    (dbg_wr && scr_hit), // R18 R19
    .a_addr  (take ? haddr[4:2] : dph_index_q[2:0]),
    .a_wdata (hwdata),
    .a_rdata (scr_rdata),
    .b_we    (cfg_scratch_we),
    .b_addr  (cfg_scratch_addr),
    .b_wdata (cfg_scratch_wdata),
    .b_rdata (cfg_scratch_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read data, one wait-free cycle: registered at the address phase

  reg [31:0] rd_d;
  reg [7:0]  ridx;
  reg        scr_rd_q;

  always @*
  begin
    ridx = haddr[9:2];
    rd_d = 32'h0000_0000; // R20
    case (ridx)
      `IDX_TILE_CELL_OSC:   rd_d = {16'h0000, osc_sync_q[15:0]};  // R1
      `IDX_TILE_WIRE_OSC:   rd_d = {16'h0000, osc_sync_q[31:16]}; // R1
      `IDX_PERIPH_CELL_OSC: rd_d = {16'h0000, osc_sync_q[47:32]}; // R1
      `IDX_PERIPH_WIRE_OSC: rd_d = {16'h0000, osc_sync_q[63:48]}; // R1
      `IDX_MEMORY_SIZE:     rd_d = {RAM_SIZE_BYTES[31:2], 2'b00}; // R3
      `IDX_SAVED_STATUS:
        rd_d = {status_q[31:9], issue_q, status_q[7:0]}; // R7
      `IDX_SAVED_PC:        rd_d = pc_q;
      `IDX_SAVED_STACK:     rd_d = stack_q;
      `IDX_FETCH_THREAD:    rd_d = {24'h000000, fthread_q};
      `IDX_FETCH_REGISTER:  rd_d = {27'h0000000, freg_q};
      `IDX_DEBUG_CAUSE:     rd_d = cause_q;
      `IDX_CAUSE_DATA:      rd_d = cdata_q;
      `IDX_STOP_MASK:       rd_d = {{(32-THREADS){1'b0}}, stop_q};
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  reg [31:0] rd_q;

  always @(posedge clock)
  begin
    if (rst)
    begin
      rd_q      <= 32'h0000_0000;
      scr_rd_q  <= 1'b0;
      rd_pend_q <= 1'b0;
    end
    else if (hready)
    begin
      rd_q      <= rd_d;
      scr_rd_q  <= (haddr[9:2] >= `IDX_SCRATCH_BASE) &&
                   (haddr[9:2] <= `IDX_SCRATCH_LAST);
      rd_pend_q <= take && !hwrite;
    end
  end

  always @*
  begin
    if (!rd_pend_q)
      hrdata = 32'h0000_0000;
    else if (scr_rd_q)
      hrdata = scr_rdata; // R18
    else
      hrdata = rd_q;
  end

endmodule // tile_debug_status_registers

/* tile_debug_status_registers_monitor.sv */
module status_regs_monitor
#(
  parameter [31:0] RAM_SIZE_BYTES = 32'h0008_0000,
  parameter        THREADS        = 8
)
(
  // clock and reset
  input wire               clock,
  input wire               rst,
  // bus
  input wire               hsel,
  input wire [31:0]        haddr,
  input wire [1:0]         htrans,
  input wire               hwrite,
  input wire               hready,
  input wire               hreadyout,
  input wire               hresp,
  input wire [31:0]        hrdata,
  // core side
  input wire               debug_mode,
  input wire [7:0]         fetch_thread,
  input wire [4:0]         fetch_register,
  input wire [THREADS-1:0] thread_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_q;
  logic [7:0] idx_q;
  logic       quiet;

  ////////////////////////////////////////////////////////////////////////
  // read data phase tracking
  always @(posedge clock)
  begin
    if (hready)
    begin
      rd_q  <= !rst & hsel & htrans[1] & !hwrite;
      idx_q <= haddr[9:2];
    end
  end
  assign quiet = !debug_mode;

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_idle_zero: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside read phase");
  a_osc_upper: assert property (
    rd_q && idx_q >= 8'h07 && idx_q <= 8'h0a |-> hrdata[31:16] == 16'h0)
    else $error("oscillator upper bits set");
  a_size_value: assert property (rd_q && idx_q == 8'h0c
    |-> hrdata == {RAM_SIZE_BYTES[31:2], 2'b00})
    else $error("memory size wrong");
  a_thread_echo: assert property (rd_q && idx_q == 8'h13
    |-> hrdata == {24'h0, $past(fetch_thread)})
    else $error("thread operand read wrong");
  a_reg_echo: assert property (rd_q && idx_q == 8'h14
    |-> hrdata == {27'h0, $past(fetch_register)})
    else $error("register operand read wrong");
  a_stop_gate: assert property (debug_mode |-> thread_stop == '0)
    else $error("threads stopped in debug mode");
  a_stop_hold: assert property (quiet && $past(quiet) &&
    $past(quiet, 2) && !$past(rst) |-> $stable(thread_stop))
    else $error("stop mask changed outside debug mode");
  a_fetch_hold: assert property (quiet && $past(quiet) &&
    $past(quiet, 2) && !$past(rst)
    |-> $stable(fetch_thread) && $stable(fetch_register))
    else $error("operand changed outside debug mode");
endmodule // status_regs_monitor

bind tile_debug_status_registers status_regs_monitor
  #(.RAM_SIZE_BYTES(RAM_SIZE_BYTES), .THREADS(THREADS)) mon_u (
  .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .hrdata, .debug_mode, .fetch_thread, .fetch_register,
  .thread_stop);

/* core_debug_model.sv */
module core_debug_model
(
  // clock
  input  wire         clock,
  // core debug state
  output logic        debug_mode,
  output logic        debug_entry,
  output logic        debug_return,
  output logic        current_issue_mode,
  output logic [2:0]  entry_cause,
  output logic [7:0]  entry_thread,
  output logic [3:0]  entry_trigger_hits,
  output logic [31:0] entry_saved_status_word,
  output logic [31:0] entry_saved_program_counter,
  output logic [31:0] entry_saved_stack_pointer,
  output logic [31:0] entry_effective_address,
  output logic [31:0] entry_resource_id
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {debug_mode, debug_entry, debug_return} = 3'h0;
    current_issue_mode = 1'b1;
    entry_cause = 3'h0;
    entry_thread = 8'h05;
    entry_trigger_hits = 4'hc;
  end

  ////////////////////////////////////////////////////////////////////////
  // one debug entry; state lines scrambled once the pulse is over
  task enter(input logic [2:0] c, input logic [31:0] d);
    @(posedge clock);
    debug_mode <= 1'b1;
    debug_entry <= 1'b1;
    entry_cause <= c;
    entry_saved_status_word <= d;
    entry_saved_program_counter <= d + 32'h1;
    entry_saved_stack_pointer <= d + 32'h2;
    entry_effective_address <= d + 32'h3;
    entry_resource_id <= d + 32'h4;
    @(posedge clock);
    debug_entry <= 1'b0;
    entry_cause <= ~c;
    entry_saved_status_word <= ~d;
    entry_saved_program_counter <= ~d;
    entry_saved_stack_pointer <= ~d;
    entry_effective_address <= ~d;
    entry_resource_id <= ~d;
  endtask

  task leave;
    @(posedge clock);
    debug_mode <= 1'b0;
    debug_return <= 1'b1;
    @(posedge clock);
    debug_return <= 1'b0;
  endtask

  // live issue mode seen by the status word
  task set_issue(input logic v);
    @(posedge clock);
    current_issue_mode <= v;
  endtask
endmodule // core_debug_model

/* tile_debug_status_registers_bench.sv */
module tile_debug_status_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = '0, rst = '1, hsel = '0, hwrite = '0;
  logic        cfg_scratch_we = '0;
  logic [1:0]  htrans = '0;
  logic [2:0]  cfg_scratch_addr = '0;
  logic [31:0] haddr = '0, hwdata = '0, cfg_scratch_wdata = '0, r, d, keep;
  logic [15:0] osc [4] = '{16'h1a01, 16'h2b02, 16'h3c03, 16'h4d04};
  int          miscompares = 0, n_compared = 0, cycles = 0;
  wire         debug_mode, debug_entry, debug_return, current_issue_mode;
  wire         hreadyout, hresp;
  wire [2:0]   entry_cause;
  wire [3:0]   entry_trigger_hits;
  wire [4:0]   fetch_register;
  wire [7:0]   entry_thread, fetch_thread, thread_stop;
  wire [31:0]  entry_saved_status_word, entry_saved_program_counter;
  wire [31:0]  entry_saved_stack_pointer, entry_effective_address;
  wire [31:0]  entry_resource_id, hrdata, cfg_scratch_rdata;

  tile_debug_status_registers dut_u (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata),
    .tile_cell_osc(osc[0]), .tile_wire_osc(osc[1]),
    .periph_cell_osc(osc[2]), .periph_wire_osc(osc[3]),
    .debug_mode(debug_mode), .debug_entry(debug_entry),
    .debug_return(debug_return),
    .entry_saved_status_word(entry_saved_status_word),
    .entry_saved_program_counter(entry_saved_program_counter),
    .entry_saved_stack_pointer(entry_saved_stack_pointer),
    .entry_cause(entry_cause), .entry_thread(entry_thread),
    .entry_trigger_hits(entry_trigger_hits),
    .entry_effective_address(entry_effective_address),
    .entry_resource_id(entry_resource_id),
    .current_issue_mode(current_issue_mode),
    .fetch_thread(fetch_thread), .fetch_register(fetch_register),
    .thread_stop(thread_stop),
    .cfg_scratch_we(cfg_scratch_we), .cfg_scratch_addr(cfg_scratch_addr),
    .cfg_scratch_wdata(cfg_scratch_wdata),
    .cfg_scratch_rdata(cfg_scratch_rdata));
  core_debug_model partner_u (
    .clock(clock), .debug_mode(debug_mode), .debug_entry(debug_entry),
    .debug_return(debug_return), .current_issue_mode(current_issue_mode),
    .entry_cause(entry_cause), .entry_thread(entry_thread),
    .entry_trigger_hits(entry_trigger_hits),
    .entry_saved_status_word(entry_saved_status_word),
    .entry_saved_program_counter(entry_saved_program_counter),
    .entry_saved_stack_pointer(entry_saved_stack_pointer),
    .entry_effective_address(entry_effective_address),
    .entry_resource_id(entry_resource_id));

  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask

  task xfer(logic w, logic [31:0] a, logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task rd(logic [31:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("addr %h", a), e, r);
  endtask

  task complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int k = 0; k < 2; k++)
    begin
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) rd(32'h1c + 4 * i, osc[i]);
      rd(32'h54, 32'h0);
      rd(32'h30, 32'h0008_0000);
    end
    keep = 32'h0;
    for (int c = 1; c < 6; c++)
    begin
      d = 32'hfedc_ba90 + c;
      partner_u.enter(c[2:0], d);
      if (c == 4) keep = d + 32'h3;
      if (c == 5) keep = d + 32'h4;
      rd(32'h40, d & 32'h06df | 32'h100);
      rd(32'h44, d + 32'h1);
      rd(32'h48, d + 32'h2);
      rd(32'h54, {14'h0, c > 2 ? 2'h2 : 2'h0,
                  c == 1 ? 8'h0 : 8'h05, 5'h0, c[2:0]});
      rd(32'h58, keep);
    end
    xfer(1'b1, 32'h4c, 32'hffff_ffff);
    rd(32'h4c, 32'hff);
    xfer(1'b1, 32'h50, 32'hffff_ffff);
    rd(32'h50, 32'h1f);
    xfer(1'b1, 32'h30, 32'h0);
    rd(32'h30, 32'h0008_0000);
    xfer(1'b1, 32'h2c, 32'h1);
    rd(32'h2c, 32'h0);
    xfer(1'b1, 32'h40, 32'h0);
    rd(32'h40, 32'h100);
    xfer(1'b1, 32'h60, 32'hffff_ffa5);
    rd(32'h60, 32'ha5);
    chk("stop", 32'h0, {24'h0, thread_stop});
    for (int i = 0; i < 8; i++)
      xfer(1'b1, 32'h80 + 4 * i, 32'h5a00_0000 + i);
    for (int i = 0; i < 8; i++) rd(32'h80 + 4 * i, 32'h5a00_0000 + i);
    @(posedge clock);
    cfg_scratch_we <= 1'b1;
    cfg_scratch_addr <= 3'h6;
    cfg_scratch_wdata <= 32'hc0de_0006;
    @(posedge clock);
    cfg_scratch_we <= 1'b0;
    cfg_scratch_addr <= 3'h3;
    repeat (2) @(posedge clock);
    chk("cfg scratch", 32'h5a00_0003, cfg_scratch_rdata);
    rd(32'h98, 32'hc0de_0006);
    partner_u.leave;
    chk("stop", 32'ha5, {24'h0, thread_stop});
    xfer(1'b1, 32'h60, 32'h0);
    rd(32'h60, 32'ha5);
    xfer(1'b1, 32'h4c, 32'h0);
    rd(32'h4c, 32'hff);
    xfer(1'b1, 32'h80, 32'h0);
    rd(32'h80, 32'h5a00_0000);
    partner_u.set_issue(1'b0);
    rd(32'h40, 32'h0);
    // mid-run reset: counts survive, cause and stop mask clear
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(32'h1c, osc[0]);
    rd(32'h54, 32'h0);
    rd(32'h60, 32'h0);
    complete_run;
  end
endmodule // tile_debug_status_registers_bench
